// >>> core/gpmc_regs.vh
// register offsets, the drive-low reset value and the unlock key of the port block
`ifndef GPMC_REGS_VH
`define GPMC_REGS_VH
`define GPMC_OFF_DATA 12'h000
`define GPMC_OFF_DIR 12'h400
`define GPMC_OFF_IS 12'h404
`define GPMC_OFF_IBE 12'h408
`define GPMC_OFF_IEV 12'h40c
`define GPMC_OFF_IM 12'h410
`define GPMC_OFF_RIS 12'h414
`define GPMC_OFF_MIS 12'h418
`define GPMC_OFF_ICR 12'h41c
`define GPMC_OFF_AFSEL 12'h420
`define GPMC_OFF_DRL 12'h500
`define GPMC_OFF_DRM 12'h504
`define GPMC_OFF_DRH 12'h508
`define GPMC_OFF_ODR 12'h50c
`define GPMC_OFF_PUR 12'h510
`define GPMC_OFF_PDR 12'h514
`define GPMC_OFF_SLR 12'h518
`define GPMC_OFF_DEN 12'h51c
`define GPMC_OFF_LOCK 12'h520
`define GPMC_OFF_CR 12'h524
`define GPMC_OFF_ID_LO 12'hfd0
`define GPMC_RST_DRL 8'hff
`define GPMC_LOCK_KEY 32'h1acc_e551
`endif

// >>> core/gpmc_port.v
// one eight-bit general-purpose port: data, pad control, commit guard and pin interrupts
`timescale 1ns/1ps
`include "gpmc_regs.vh"
module gpmc_port #(
	parameter WIDTH = 8,
	parameter [7:0] DEBUG_PINS = 8'h00,
	parameter IS_PORT_B = 0,
	parameter [7:0] ID0 = 8'h5a,
	parameter [7:0] ID1 = 8'h3c
) (
	input wire clk_sys,
	input wire srst,
	input wire [11:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	output reg [31:0] avs_readdata,
	output wire avs_waitrequest,
	input wire [WIDTH-1:0] pin_in,
	output reg [WIDTH-1:0] pin_out,
	output reg [WIDTH-1:0] pin_oe,
	input wire [WIDTH-1:0] alt_out,
	input wire [WIDTH-1:0] alt_oe,
	output reg [WIDTH-1:0] alt_in,
	output reg [WIDTH-1:0] pad_pull_up,
	output reg [WIDTH-1:0] pad_pull_down,
	output reg [WIDTH-1:0] pad_input_enable,
	output reg [WIDTH-1:0] pad_drive_low,
	output reg [WIDTH-1:0] pad_drive_mid,
	output reg [WIDTH-1:0] pad_drive_high,
	output reg [WIDTH-1:0] pad_slew,
	output reg [WIDTH-1:0] pad_analog,
	output reg port_irq,
	output reg conv_trigger
);
	// identification bytes are arbitrary values
	reg [WIDTH-1:0] pin_data_register_q;
	reg [WIDTH-1:0] pin_direction_q;
	reg [WIDTH-1:0] int_sense_select_q;
	reg [WIDTH-1:0] int_both_edges_select_q;
	reg [WIDTH-1:0] int_event_polarity_q;
	reg [WIDTH-1:0] int_mask_q;
	reg [WIDTH-1:0] edge_latch_q;
	reg [WIDTH-1:0] alt_function_select_q;
	reg [WIDTH-1:0] drive_low_select_q;
	reg [WIDTH-1:0] drive_mid_select_q;
	reg [WIDTH-1:0] drive_high_select_q;
	reg [WIDTH-1:0] open_drain_select_q;
	reg [WIDTH-1:0] pull_up_select_q;
	reg [WIDTH-1:0] pull_down_select_q;
	reg [WIDTH-1:0] slew_rate_select_q;
	reg [WIDTH-1:0] digital_input_enable_q;
	reg [WIDTH-1:0] commit_permission_q;
	reg unlocked_q;
	reg [WIDTH-1:0] sync1_q;
	reg [WIDTH-1:0] sync2_q;
	reg [WIDTH-1:0] sync3_q;
	reg [WIDTH-1:0] prev_q;
	reg ack_q;
	reg [WIDTH-1:0] edge_hit;
	reg [WIDTH-1:0] level_hit;
	reg [WIDTH-1:0] int_raw_status;
	reg [WIDTH-1:0] int_masked_status;
	reg [WIDTH-1:0] pin_val;
	reg [31:0] rd_d;
	wire wr_en;
	wire [WIDTH-1:0] wmask;
	wire [WIDTH-1:0] wdata;
	// every access answers one cycle after the request appears
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
	// a write lands at the edge where waitrequest is seen low
	assign wr_en = avs_write & ack_q;
	assign wdata = avs_writedata[WIDTH-1:0];
	assign wmask = avs_address[9:2];
	always @(posedge clk_sys) begin
		if (srst) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (avs_read | avs_write) & ~ack_q;
		end
	end
	// three-stage input synchroniser; changes counted when stages two and three agree
	always @(posedge clk_sys) begin : sync_p
		integer i;
		if (srst) begin
			sync1_q <= {WIDTH{1'b0}};
			sync2_q <= {WIDTH{1'b0}};
			sync3_q <= {WIDTH{1'b0}};
			prev_q <= {WIDTH{1'b0}};
		end else begin
			sync1_q <= pin_in;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			for (i = 0; i < WIDTH; i = i + 1) begin
				if (sync2_q[i] == sync3_q[i]) begin
					prev_q[i] <= sync3_q[i];
				end
			end
		end
	end
	always @* begin : detect_p
		integer i;
		for (i = 0; i < WIDTH; i = i + 1) begin
			pin_val[i] = prev_q[i];
			// edge from previous settled sample vs newly agreed sample
			edge_hit[i] = 1'b0;
			if (sync2_q[i] == sync3_q[i] && sync3_q[i] != prev_q[i]) begin
				if (int_both_edges_select_q[i]) begin
					edge_hit[i] = 1'b1;
				end else begin
					edge_hit[i] = (sync3_q[i] == int_event_polarity_q[i]);
				end
			end
			level_hit[i] = (prev_q[i] == int_event_polarity_q[i]);
			int_raw_status[i] = int_sense_select_q[i] ? level_hit[i] : edge_latch_q[i];
		end
		int_masked_status = int_raw_status & int_mask_q;
	end
	// edge latch: new edge wins over a clear in the same cycle
	always @(posedge clk_sys) begin : latch_p
		integer i;
		if (srst) begin
			edge_latch_q <= {WIDTH{1'b0}};
		end else begin
			for (i = 0; i < WIDTH; i = i + 1) begin
				if (edge_hit[i] && !int_sense_select_q[i]) begin
					edge_latch_q[i] <= 1'b1;
				end else if (wr_en && avs_address == `GPMC_OFF_ICR && wdata[i]) begin
					edge_latch_q[i] <= 1'b0;
				end
			end
		end
	end
	always @(posedge clk_sys) begin
		if (srst) begin
			port_irq <= 1'b0;
			conv_trigger <= 1'b0;
		end else begin
			port_irq <= |int_masked_status;
			// port B only: trigger pulses on each pin-four edge that sets edge_hit while unmasked, and stays high while a sensed level holds
			conv_trigger <= (IS_PORT_B != 0) && int_mask_q[4] &&
				(int_sense_select_q[4] ? level_hit[4] : edge_hit[4]);
		end
	end
	// register writes
	always @(posedge clk_sys) begin : write_p
		integer i;
		if (srst) begin
			pin_data_register_q <= {WIDTH{1'b0}};
			pin_direction_q <= {WIDTH{1'b0}};
			int_sense_select_q <= {WIDTH{1'b0}};
			int_both_edges_select_q <= {WIDTH{1'b0}};
			int_event_polarity_q <= {WIDTH{1'b0}};
			int_mask_q <= {WIDTH{1'b0}};
			alt_function_select_q <= DEBUG_PINS;
			drive_low_select_q <= `GPMC_RST_DRL;
			drive_mid_select_q <= {WIDTH{1'b0}};
			drive_high_select_q <= {WIDTH{1'b0}};
			open_drain_select_q <= {WIDTH{1'b0}};
			pull_up_select_q <= DEBUG_PINS;
			pull_down_select_q <= {WIDTH{1'b0}};
			slew_rate_select_q <= {WIDTH{1'b0}};
			digital_input_enable_q <= DEBUG_PINS;
			commit_permission_q <= ~DEBUG_PINS;
			unlocked_q <= 1'b0;
		end else begin
			for (i = 0; i < WIDTH; i = i + 1) begin
				if (!pin_direction_q[i]) begin
					pin_data_register_q[i] <= pin_val[i];
				end else if (wr_en && avs_address[11:10] == 2'b00 && wmask[i]) begin
					pin_data_register_q[i] <= wdata[i];
				end
			end
			if (wr_en) begin
				case (avs_address)
					`GPMC_OFF_DIR: begin
						pin_direction_q <= wdata;
					end
					`GPMC_OFF_IS: begin
						int_sense_select_q <= wdata;
					end
					`GPMC_OFF_IBE: begin
						int_both_edges_select_q <= wdata;
					end
					`GPMC_OFF_IEV: begin
						int_event_polarity_q <= wdata;
					end
					`GPMC_OFF_IM: begin
						int_mask_q <= wdata;
					end
					`GPMC_OFF_AFSEL: begin
						for (i = 0; i < WIDTH; i = i + 1) begin
							if (!DEBUG_PINS[i] || (unlocked_q && commit_permission_q[i])) begin
								alt_function_select_q[i] <= wdata[i];
							end
						end
					end
					`GPMC_OFF_DRL: begin
						drive_low_select_q <= wdata;
					end
					`GPMC_OFF_DRM: begin
						drive_mid_select_q <= wdata;
					end
					`GPMC_OFF_DRH: begin
						drive_high_select_q <= wdata;
					end
					`GPMC_OFF_ODR: begin
						open_drain_select_q <= wdata;
					end
					`GPMC_OFF_PUR: begin
						pull_up_select_q <= wdata;
					end
					`GPMC_OFF_PDR: begin
						pull_down_select_q <= wdata;
					end
					`GPMC_OFF_SLR: begin
						slew_rate_select_q <= wdata;
					end
					`GPMC_OFF_DEN: begin
						digital_input_enable_q <= wdata;
					end
					`GPMC_OFF_LOCK: begin
						unlocked_q <= (avs_writedata == `GPMC_LOCK_KEY);
					end
					`GPMC_OFF_CR: begin
						if (unlocked_q) begin
							commit_permission_q <= (wdata & DEBUG_PINS) | ~DEBUG_PINS;
						end
					end
					default: begin
					end
				endcase
			end
		end
	end
	// pad and pin steering
	always @(posedge clk_sys) begin : pad_p
		integer i;
		if (srst) begin
			pin_out <= {WIDTH{1'b0}};
			pin_oe <= {WIDTH{1'b0}};
			alt_in <= {WIDTH{1'b0}};
			pad_pull_up <= DEBUG_PINS;
			pad_pull_down <= {WIDTH{1'b0}};
			pad_input_enable <= DEBUG_PINS;
			pad_drive_low <= {WIDTH{1'b0}};
			pad_drive_mid <= {WIDTH{1'b0}};
			pad_drive_high <= {WIDTH{1'b0}};
			pad_slew <= {WIDTH{1'b0}};
			pad_analog <= {WIDTH{1'b0}};
		end else begin
			for (i = 0; i < WIDTH; i = i + 1) begin
				if (alt_function_select_q[i]) begin
					pin_out[i] <= open_drain_select_q[i] ? 1'b0 : alt_out[i];
					pin_oe[i] <= digital_input_enable_q[i] &
						(open_drain_select_q[i] ? (alt_oe[i] & ~alt_out[i]) : alt_oe[i]);
				end else begin
					pin_out[i] <= open_drain_select_q[i] ? 1'b0 : pin_data_register_q[i];
					pin_oe[i] <= digital_input_enable_q[i] & pin_direction_q[i] &
						(~open_drain_select_q[i] | ~pin_data_register_q[i]);
				end
				alt_in[i] <= digital_input_enable_q[i] & prev_q[i];
				pad_pull_up[i] <= pull_up_select_q[i];
				pad_pull_down[i] <= pull_down_select_q[i];
				pad_input_enable[i] <= digital_input_enable_q[i];
				// drive and slew only count while the pin is set as output or to its alternate function
				pad_drive_low[i] <= drive_low_select_q[i] & (alt_function_select_q[i] | pin_direction_q[i]);
				pad_drive_mid[i] <= drive_mid_select_q[i] & (alt_function_select_q[i] | pin_direction_q[i]);
				pad_drive_high[i] <= drive_high_select_q[i] & (alt_function_select_q[i] | pin_direction_q[i]);
				pad_slew[i] <= slew_rate_select_q[i] & (alt_function_select_q[i] | pin_direction_q[i]);
				pad_analog[i] <= ~(alt_function_select_q[i] | pin_direction_q[i] | open_drain_select_q[i] |
					digital_input_enable_q[i] | pull_up_select_q[i] | pull_down_select_q[i]);
			end
		end
	end
	// read mux
	always @* begin
		rd_d = 32'h0000_0000;
		if (avs_address[11:10] == 2'b00) begin
			rd_d[WIDTH-1:0] = pin_data_register_q & wmask;
		end else begin
			case (avs_address)
				`GPMC_OFF_DIR: begin
					rd_d[WIDTH-1:0] = pin_direction_q;
				end
				`GPMC_OFF_IS: begin
					rd_d[WIDTH-1:0] = int_sense_select_q;
				end
				`GPMC_OFF_IBE: begin
					rd_d[WIDTH-1:0] = int_both_edges_select_q;
				end
				`GPMC_OFF_IEV: begin
					rd_d[WIDTH-1:0] = int_event_polarity_q;
				end
				`GPMC_OFF_IM: begin
					rd_d[WIDTH-1:0] = int_mask_q;
				end
				`GPMC_OFF_RIS: begin
					rd_d[WIDTH-1:0] = int_raw_status;
				end
				`GPMC_OFF_MIS: begin
					rd_d[WIDTH-1:0] = int_masked_status;
				end
				`GPMC_OFF_AFSEL: begin
					rd_d[WIDTH-1:0] = alt_function_select_q;
				end
				`GPMC_OFF_DRL: begin
					rd_d[WIDTH-1:0] = drive_low_select_q;
				end
				`GPMC_OFF_DRM: begin
					rd_d[WIDTH-1:0] = drive_mid_select_q;
				end
				`GPMC_OFF_DRH: begin
					rd_d[WIDTH-1:0] = drive_high_select_q;
				end
				`GPMC_OFF_ODR: begin
					rd_d[WIDTH-1:0] = open_drain_select_q;
				end
				`GPMC_OFF_PUR: begin
					rd_d[WIDTH-1:0] = pull_up_select_q;
				end
				`GPMC_OFF_PDR: begin
					rd_d[WIDTH-1:0] = pull_down_select_q;
				end
				`GPMC_OFF_SLR: begin
					rd_d[WIDTH-1:0] = slew_rate_select_q;
				end
				`GPMC_OFF_DEN: begin
					rd_d[WIDTH-1:0] = digital_input_enable_q;
				end
				`GPMC_OFF_LOCK: begin
					rd_d[0] = ~unlocked_q;
				end
				`GPMC_OFF_CR: begin
					rd_d[WIDTH-1:0] = commit_permission_q;
				end
				`GPMC_OFF_ID_LO: rd_d[7:0] = ID0;
				`GPMC_OFF_ID_LO + 12'h004: rd_d[7:0] = ID1;
				default: rd_d = 32'h0000_0000;
			endcase
		end
	end
	always @(posedge clk_sys) begin
		if (srst) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read & ~ack_q) begin
			avs_readdata <= rd_d;
		end
	end
endmodule // gpmc_port

// >>> dv/gpmc_port_chk.sv
// concurrent checks on the port block's bus, pad and interrupt pins
`timescale 1ns/1ps
module gpmc_port_chk #(
	parameter [7:0] DEBUG_PINS = 8'h00
) (
	input wire clk_sys,
	input wire srst,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_readdata,
	input wire avs_waitrequest,
	input wire [7:0] alt_oe,
	input wire [7:0] pin_oe,
	input wire [7:0] pad_pull_up,
	input wire [7:0] pad_pull_down,
	input wire [7:0] pad_input_enable,
	input wire [7:0] pad_analog,
	input wire port_irq,
	input wire conv_trigger
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	wire req = avs_read | avs_write;
	sequence s_first;
		req && !$past(req);
	endsequence
	a_wait_first: assert property (s_first |-> avs_waitrequest) else $error("no wait on new request");
	a_wait_bound: assert property (s_first |=> !avs_waitrequest) else $error("bus answer late");
	a_rd_stable: assert property (!avs_read |=> $stable(avs_readdata)) else $error("read data moved");
	a_reset_pads: assert property ($past(srst) |-> pad_pull_up == DEBUG_PINS
		&& pad_input_enable == DEBUG_PINS && pad_pull_down == 8'h00 && pin_oe == 8'h00)
		else $error("pad reset state wrong");
	a_analog_excl: assert property ((pad_analog & (pad_pull_up | pad_pull_down | pad_input_enable)) == 8'h00)
		else $error("analog with digital setting");
	a_trig_irq: assert property (conv_trigger |-> ##[0:4] port_irq) else $error("trigger without irq");
	a_pad_steady: assert property (!avs_write [*2] |=> $stable(pad_pull_up) && $stable(pad_pull_down))
		else $error("pad setting moved");
	a_oe_steady: assert property ((!avs_write && $stable(alt_oe)) [*2] |=> $stable(pin_oe))
		else $error("pin enable moved");
endmodule // gpmc_port_chk
bind gpmc_port gpmc_port_chk #(.DEBUG_PINS(DEBUG_PINS)) gpmc_port_chk_i (.clk_sys(clk_sys), .srst(srst),
	.avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.alt_oe(alt_oe), .pin_oe(pin_oe), .pad_pull_up(pad_pull_up), .pad_pull_down(pad_pull_down),
	.pad_input_enable(pad_input_enable), .pad_analog(pad_analog), .port_irq(port_irq),
	.conv_trigger(conv_trigger));

// >>> dv/gpmc_periph.sv
// peripheral model: drives the alternate side of the pins and counts converter triggers
`timescale 1ns/1ps
module gpmc_periph (
	input wire clk_sys,
	input wire srst,
	input wire [7:0] oe_req,
	input wire [7:0] alt_in,
	input wire conv_trigger,
	output reg [7:0] alt_out,
	output reg [7:0] alt_oe,
	output reg [7:0] trig_cnt
);
	always @(posedge clk_sys) begin
		alt_out <= srst ? 8'h5a : ~alt_out ^ alt_in;
		alt_oe <= oe_req;
		trig_cnt <= srst ? 8'h00 : trig_cnt + {7'h00, conv_trigger};
	end
endmodule // gpmc_periph

// >>> dv/gpmc_port_tb.sv
// self-checking bench of the port block with a peripheral model
`timescale 1ns/1ps
`include "gpmc_regs.vh"
module gpmc_port_tb;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic [11:0] avs_address = 12'h000;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [7:0] pin_in = 8'h00;
	logic [7:0] oe_req = 8'h00;
	wire [31:0] avs_readdata;
	wire avs_waitrequest, port_irq, conv_trigger;
	wire [7:0] pin_out, pin_oe, alt_out, alt_oe, alt_in, trig_cnt;
	int err_total = 0;
	int n_tests = 0;
	int raw, hits, m, i;
	logic [7:0] base;
	logic [31:0] q, dir, d;
	logic [2:0] md [5] = '{3'b000, 3'b001, 3'b010, 3'b101, 3'b100};
	logic [11:0] ra [10] = '{`GPMC_OFF_DIR, `GPMC_OFF_AFSEL, `GPMC_OFF_DRL, `GPMC_OFF_PUR, `GPMC_OFF_DEN,
		`GPMC_OFF_PDR, `GPMC_OFF_LOCK, `GPMC_OFF_ID_LO, 12'hfd4, 12'h600};
	logic [31:0] rv [10] = '{0, 32'h80, 32'hff, 32'h80, 32'h80, 0, 1, 32'h5a, 32'h3c, 0};
	gpmc_port #(.DEBUG_PINS(8'h80), .IS_PORT_B(1)) gpmc_port_i (.clk_sys, .srst, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .pin_in, .pin_out, .pin_oe, .alt_out,
		.alt_oe, .alt_in, .pad_pull_up(), .pad_pull_down(), .pad_input_enable(), .pad_drive_low(),
		.pad_drive_mid(), .pad_drive_high(), .pad_slew(), .pad_analog(), .port_irq, .conv_trigger);
	gpmc_periph gpmc_periph_i (.clk_sys, .srst, .oe_req, .alt_in, .conv_trigger, .alt_out, .alt_oe, .trig_cnt);
	initial forever #20 clk_sys = ~clk_sys;
	task automatic print_verdict;
		$display("errors %0d of %0d checks", err_total, n_tests);
		if (err_total == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected reg at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected pin at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] dw);
		int n;
		@(posedge clk_sys);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= dw;
		n = 0;
		@(negedge clk_sys);
		while (avs_waitrequest !== 1'b0 && n < 50) begin
			@(negedge clk_sys);
			n++;
		end
		if (n >= 50) err_total++;
		q = avs_readdata;
		@(posedge clk_sys);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] dw);
		bus(1'b1, a, dw);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk_reg(q, e);
	endtask
	// moves pin four, updates the model and compares status and interrupt line
	task automatic step(input logic v);
		logic o;
		o = pin_in[4];
		@(posedge clk_sys);
		pin_in[4] <= v;
		if (md[m][2]) raw = (v == md[m][0]);
		else if (v != o && (md[m][1] || v == md[m][0])) begin
			raw = 1;
			hits++;
		end
		repeat (6) @(posedge clk_sys);
		rd(`GPMC_OFF_RIS, 32'(raw << 4));
		rd(`GPMC_OFF_MIS, 32'(raw << 4));
		chk_pin({7'h0, port_irq}, 8'(raw));
	endtask
	initial begin
		#400000;
		err_total++;
		print_verdict;
	end
	initial begin
		void'($urandom(20236));
		repeat (12) @(posedge clk_sys);
		srst <= 1'b0;
		for (i = 0; i < 10; i++) rd(ra[i], rv[i]);
		dir = $urandom & 32'h7f;
		d = $urandom;
		pin_in <= 8'($urandom);
		wr(`GPMC_OFF_DEN, 32'hff);
		wr(`GPMC_OFF_DIR, dir);
		wr(12'h3fc, d);
		repeat (4) @(posedge clk_sys);
		rd(12'h1fc, ((dir & d) | (~dir & {24'h0, pin_in})) & 32'h7f);
		chk_pin(pin_oe & 8'h7f, dir[7:0]);
		chk_pin(pin_out & dir[7:0], d[7:0] & dir[7:0]);
		oe_req <= 8'h80;
		repeat (4) @(posedge clk_sys);
		chk_pin(pin_oe & 8'h80, 8'h80);
		wr(`GPMC_OFF_AFSEL, 0);
		rd(`GPMC_OFF_AFSEL, 32'h80);
		wr(`GPMC_OFF_LOCK, `GPMC_LOCK_KEY);
		wr(`GPMC_OFF_CR, 32'hff);
		wr(`GPMC_OFF_AFSEL, 0);
		rd(`GPMC_OFF_AFSEL, 0);
		repeat (4) @(posedge clk_sys);
		chk_pin(pin_oe & 8'h80, 8'h00);
		pin_in <= 8'h00;
		for (m = 0; m < 5; m++) begin
			wr(`GPMC_OFF_IM, 0);
			pin_in[4] <= md[m][2] & !md[m][0];
			wr(`GPMC_OFF_IS, {27'h0, md[m][2], 4'h0});
			wr(`GPMC_OFF_IBE, {27'h0, md[m][1], 4'h0});
			wr(`GPMC_OFF_IEV, {27'h0, md[m][0], 4'h0});
			repeat (6) @(posedge clk_sys);
			wr(`GPMC_OFF_ICR, 32'hff);
			raw = 0;
			hits = 0;
			base = trig_cnt;
			wr(`GPMC_OFF_IM, 32'h10);
			step(!pin_in[4]);
			step(!pin_in[4]);
			wr(`GPMC_OFF_IM, 0);
			repeat (2) @(posedge clk_sys);
			rd(`GPMC_OFF_RIS, 32'(raw << 4));
			rd(`GPMC_OFF_MIS, 0);
			chk_pin({7'h0, port_irq}, 8'h00);
			wr(`GPMC_OFF_ICR, 32'hef);
			rd(`GPMC_OFF_RIS, 32'(raw << 4));
			wr(`GPMC_OFF_ICR, 32'h10);
			rd(`GPMC_OFF_RIS, 0);
			if (!md[m][2]) chk_pin(8'(trig_cnt - base), 8'(hits));
		end
		print_verdict;
	end
endmodule // gpmc_port_tb
